/* core/amlf_top.sv */
// Alarm mask, alarm status and per-lane FIFO alarm registers, AXI4-Lite slave.
// Assumes alarm sources are synchronous level inputs on clk_in.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (RQ1) Mask bit 5 set keeps FIFO alarm status out of the summary.
// (RQ2) Mask bit 4 set keeps lock-lost status out of the summary.
// (RQ3) Mask bit 3 set keeps link alarm status out of the summary.
// (RQ4) Mask bit 2 set keeps realignment status out of the summary.
// (RQ5) Mask bit 0 set keeps divider mismatch status out of the summary.
// (RQ6) Mask bit 1 is stored and read back only, no effect.
// (RQ7) Lane i FIFO overflow or underflow sets lane flag bit i.
// (RQ8) Writing one clears a lane flag bit; zero leaves it.
// (RQ9) A persisting lane fault sets its flag again at once.
// (RQ10) Writing one to status FIFO bit clears all lane flags.
// (RQ11) Lane flags reset to all ones.
// (RQ12) Any lane fault sets the FIFO status bit; writing one clears it.
// (RQ13) All alarm status bits reset to one.
// (RQ14) Summary is OR of unmasked status bits, registered one cycle later; status bit 1 is left out of the OR.
module amlf_top (
   // Clock and reset
   input  wire logic                               clk_in,
   input  wire logic                               rst_n_in,
   // Alarm sources
   input  wire logic [amlf_pkg::AMLF_LANES-1:0]    lane_fault_in,
   input  wire logic                               lock_lost_in,
   input  wire logic                               link_fault_in,
   input  wire logic                               clock_realign_in,
   input  wire logic                               divider_mismatch_in,
   // AXI4-Lite write address
   input  wire logic [amlf_pkg::AMLF_ADDR_W-1:0]   s_axi_awaddr_in,
   input  wire logic                               s_axi_awvalid_in,
   output logic                                    s_axi_awready_out,
   // AXI4-Lite write data
   input  wire logic [31:0]                        s_axi_wdata_in,
   input  wire logic [3:0]                         s_axi_wstrb_in,
   input  wire logic                               s_axi_wvalid_in,
   output logic                                    s_axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0]                              s_axi_bresp_out,
   output logic                                    s_axi_bvalid_out,
   input  wire logic                               s_axi_bready_in,
   // AXI4-Lite read address
   input  wire logic [amlf_pkg::AMLF_ADDR_W-1:0]   s_axi_araddr_in,
   input  wire logic                               s_axi_arvalid_in,
   output logic                                    s_axi_arready_out,
   // AXI4-Lite read data
   output logic [31:0]                             s_axi_rdata_out,
   output logic [1:0]                              s_axi_rresp_out,
   output logic                                    s_axi_rvalid_out,
   input  wire logic                               s_axi_rready_in,
   // Alarm outputs
   output logic                                    summary_alarm_out,
   output logic                                    irq_out
);
   import amlf_pkg::*;

   // Bus state
   logic                  aw_held, next_aw_held;
   logic                  w_held, next_w_held;
   logic [AMLF_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0]           w_data, next_w_data;
   logic [3:0]            w_strb, next_w_strb;
   logic                  bvalid, next_bvalid;
   logic [1:0]            bresp, next_bresp;
   logic                  rvalid, next_rvalid;
   logic [1:0]            rresp, next_rresp;
   logic [31:0]           rdata, next_rdata;
   // Alarm state
   logic [AMLF_ALM_W-1:0] alarm_status_register, next_alarm_status_register;
   logic [AMLF_ALM_W-1:0] alarm_source_mask, next_alarm_source_mask;
   logic [AMLF_LANES-1:0] lane_fifo_fault_flags, next_lane_fifo_fault_flags;
   logic                  summary, next_summary;
   logic [AMLF_IRQ_W-1:0] irq_status, next_irq_status;
   logic [AMLF_IRQ_W-1:0] irq_mask, next_irq_mask;
   // Decoded strobes
   logic                  wr_fire, rd_fire;
   logic [AMLF_ALM_W-1:0] alarm_events;
   logic [AMLF_ALM_W-1:0] status_clear;
   logic [AMLF_LANES-1:0] lane_clear;
   logic [AMLF_IRQ_W-1:0] irq_events;
   logic                  next_lane_any;
   logic                  lane_any;

   // Address is a mapped register
   function automatic logic amlf_mapped(input logic [AMLF_ADDR_W-1:0] a);
      amlf_mapped = (a == AMLF_ADDR_SUMMARY) || (a == AMLF_ADDR_STATUS) ||
                    (a == AMLF_ADDR_MASK) || (a == AMLF_ADDR_LANE) ||
                    (a == AMLF_ADDR_IRQ_ST) || (a == AMLF_ADDR_IRQ_MSK);
   endfunction : amlf_mapped

   // Bus handshake and alarm outputs
   assign s_axi_awready_out = !aw_held && !bvalid;
   assign s_axi_wready_out  = !w_held && !bvalid;
   assign s_axi_arready_out = !rvalid;
   assign s_axi_bvalid_out  = bvalid;
   assign s_axi_bresp_out   = bresp;
   assign s_axi_rvalid_out  = rvalid;
   assign s_axi_rresp_out   = rresp;
   assign s_axi_rdata_out   = rdata;
   assign summary_alarm_out = summary;
   assign irq_out           = |(irq_status & ~irq_mask);

   // Write fires once address and data are both held
   assign wr_fire = aw_held && w_held && !bvalid;
   assign rd_fire = s_axi_arvalid_in && !rvalid;

   // Source events
   always_comb begin
      alarm_events                = '0;
      alarm_events[AMLF_BIT_DIV]  = divider_mismatch_in;
      alarm_events[AMLF_BIT_REAL] = clock_realign_in;
      alarm_events[AMLF_BIT_LINK] = link_fault_in;
      alarm_events[AMLF_BIT_LOCK] = lock_lost_in;
      alarm_events[AMLF_BIT_FIFO] = |lane_fault_in;              // RQ12
   end

   // Write-one clear strobes
   always_comb begin
      status_clear = '0;
      lane_clear   = '0;
      if (wr_fire && w_strb[0] && aw_addr == AMLF_ADDR_STATUS) begin
         status_clear = w_data[AMLF_ALM_W-1:0];
      end
      if (wr_fire && aw_addr == AMLF_ADDR_LANE) begin
         lane_clear[7:0]  = w_strb[0] ? w_data[7:0] : 8'h00;    // RQ8
         lane_clear[15:8] = w_strb[1] ? w_data[15:8] : 8'h00;   // RQ8
      end
      if (status_clear[AMLF_BIT_FIFO]) begin
         lane_clear = '1;                                       // RQ10
      end
   end

   // Bus next state
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rresp   = rresp;
      next_rdata   = rdata;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata_in;
         next_w_strb = s_axi_wstrb_in;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = amlf_mapped(aw_addr) ? AMLF_RESP_OKAY : AMLF_RESP_SLVERR;
      end else if (bvalid && s_axi_bready_in) begin
         next_bvalid = 1'b0;
      end
      if (rd_fire) begin
         next_rvalid = 1'b1;
         next_rresp  = amlf_mapped(s_axi_araddr_in) ? AMLF_RESP_OKAY : AMLF_RESP_SLVERR;
         next_rdata  = '0;
         unique case (s_axi_araddr_in)
            AMLF_ADDR_SUMMARY: next_rdata[0] = summary;
            AMLF_ADDR_STATUS:  next_rdata[AMLF_ALM_W-1:0] = alarm_status_register;
            AMLF_ADDR_MASK:    next_rdata[AMLF_ALM_W-1:0] = alarm_source_mask;  // RQ6
            AMLF_ADDR_LANE:    next_rdata[AMLF_LANES-1:0] = lane_fifo_fault_flags;
            AMLF_ADDR_IRQ_ST:  next_rdata[AMLF_IRQ_W-1:0] = irq_status;
            AMLF_ADDR_IRQ_MSK: next_rdata[AMLF_IRQ_W-1:0] = irq_mask;
            default:           next_rdata = '0;
         endcase
      end else if (rvalid && s_axi_rready_in) begin
         next_rvalid = 1'b0;
      end
   end

   // Alarm next state; set wins over clear
   always_comb begin
      next_alarm_source_mask = alarm_source_mask;
      next_irq_mask          = irq_mask;
      if (wr_fire && w_strb[0] && aw_addr == AMLF_ADDR_MASK) begin
         next_alarm_source_mask = w_data[AMLF_ALM_W-1:0];              // RQ6
      end
      if (wr_fire && w_strb[0] && aw_addr == AMLF_ADDR_IRQ_MSK) begin
         next_irq_mask = w_data[AMLF_IRQ_W-1:0];
      end
      next_alarm_status_register = (alarm_status_register & ~status_clear)
                                   | alarm_events;                     // RQ12
      next_lane_fifo_fault_flags = (lane_fifo_fault_flags & ~lane_clear)
                                   | lane_fault_in;                    // RQ7 RQ9
      // Unmasked OR, bit 1 excluded
      next_summary = (alarm_status_register[AMLF_BIT_FIFO] & ~alarm_source_mask[AMLF_BIT_FIFO])
                   | (alarm_status_register[AMLF_BIT_LOCK] & ~alarm_source_mask[AMLF_BIT_LOCK])
                   | (alarm_status_register[AMLF_BIT_LINK] & ~alarm_source_mask[AMLF_BIT_LINK])
                   | (alarm_status_register[AMLF_BIT_REAL] & ~alarm_source_mask[AMLF_BIT_REAL])
                   | (alarm_status_register[AMLF_BIT_DIV] & ~alarm_source_mask[AMLF_BIT_DIV]);
      // RQ1 RQ2 RQ3 RQ4 RQ5 RQ14
      next_lane_any = |lane_fault_in;
      irq_events                = '0;
      irq_events[AMLF_IRQ_SUM]  = next_summary && !summary;
      irq_events[AMLF_IRQ_LANE] = next_lane_any && !lane_any;
      next_irq_status = irq_status | irq_events;
      if (rd_fire && s_axi_araddr_in == AMLF_ADDR_IRQ_ST) begin
         next_irq_status = irq_events;
      end
   end

   // Registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_held               <= 1'b0;
         w_held                <= 1'b0;
         aw_addr               <= '0;
         w_data                <= '0;
         w_strb                <= '0;
         bvalid                <= 1'b0;
         bresp                 <= AMLF_RESP_OKAY;
         rvalid                <= 1'b0;
         rresp                 <= AMLF_RESP_OKAY;
         rdata                 <= '0;
         alarm_status_register <= AMLF_RST_STATUS;   // RQ13
         alarm_source_mask     <= AMLF_RST_MASK;
         lane_fifo_fault_flags <= AMLF_RST_LANE;     // RQ11
         summary               <= 1'b0;
         lane_any              <= 1'b0;
         irq_status            <= AMLF_RST_IRQ_ST;
         irq_mask              <= AMLF_RST_IRQ_MK;
      end else begin
         aw_held               <= next_aw_held;
         w_held                <= next_w_held;
         aw_addr               <= next_aw_addr;
         w_data                <= next_w_data;
         w_strb                <= next_w_strb;
         bvalid                <= next_bvalid;
         bresp                 <= next_bresp;
         rvalid                <= next_rvalid;
         rresp                 <= next_rresp;
         rdata                 <= next_rdata;
         alarm_status_register <= next_alarm_status_register;
         alarm_source_mask     <= next_alarm_source_mask;
         lane_fifo_fault_flags <= next_lane_fifo_fault_flags;
         summary               <= next_summary;
         lane_any              <= next_lane_any;
         irq_status            <= next_irq_status;
         irq_mask              <= next_irq_mask;
      end
   end

   // Checks
   // Write of one to the status FIFO bit while no lane is faulting
   sequence s_fifo_w1c;
      status_clear[AMLF_BIT_FIFO] && lane_fault_in == 16'h0000;
   endsequence
   // Any write-one clear reaching the lane flags
   sequence s_lane_w1c;
      lane_clear != 16'h0000;
   endsequence
   // Accepted write to the mask register
   sequence s_mask_wr;
      wr_fire && w_strb[0] && aw_addr == AMLF_ADDR_MASK;
   endsequence
   a_fifo_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ1
      (alarm_source_mask == 6'h20) |=> (summary == |(($past(alarm_status_register)) & 6'h1D)))
      else $error("fifo mask not honoured");
   a_lock_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ2
      (alarm_source_mask[AMLF_BIT_LOCK] && alarm_status_register == 6'h10) |=> !summary)
      else $error("lock mask not honoured");
   a_link_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ3
      (alarm_source_mask[AMLF_BIT_LINK] && alarm_status_register == 6'h08) |=> !summary)
      else $error("link mask not honoured");
   a_real_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ4
      (alarm_source_mask[AMLF_BIT_REAL] && alarm_status_register == 6'h04) |=> !summary)
      else $error("realign mask not honoured");
   a_div_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ5
      (alarm_source_mask[AMLF_BIT_DIV] && alarm_status_register == 6'h01) |=> !summary)
      else $error("divider mask not honoured");
   a_nco_inert: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ6
      (alarm_status_register == 6'h02) |=> !summary)
      else $error("unused bit drove summary");
   a_mask_store: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ6
      s_mask_wr |=> (alarm_source_mask == $past(w_data[AMLF_ALM_W-1:0])))
      else $error("mask write not stored");
   a_lane_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ7 RQ9
      (lane_fault_in != 16'h0000) |=> ((lane_fifo_fault_flags & $past(lane_fault_in))
                                       == $past(lane_fault_in)))
      else $error("lane fault not flagged");
   a_lane_w1c: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ8
      s_lane_w1c |=> ((lane_fifo_fault_flags & $past(lane_clear & ~lane_fault_in)) == 16'h0000))
      else $error("lane flag not cleared");
   a_bulk_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ10
      s_fifo_w1c |=> (lane_fifo_fault_flags == 16'h0000))
      else $error("bulk lane clear failed");
   a_fifo_status: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ12
      (|lane_fault_in) |=> alarm_status_register[AMLF_BIT_FIFO])
      else $error("fifo status not set");
   a_fifo_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ12
      s_fifo_w1c |=> !alarm_status_register[AMLF_BIT_FIFO])
      else $error("fifo status not cleared");
   a_summary_or: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RQ14
      (alarm_source_mask == 6'h00) |=> (summary == |($past(alarm_status_register) & 6'h3D)))
      else $error("summary not unmasked or");
endmodule : amlf_top

`default_nettype wire

/* pkg/amlf_pkg.sv */
// Package for the alarm mask and lane FIFO alarm block.
// Assumes a 32-bit AXI4-Lite register bus, byte addresses.
package amlf_pkg;
   // Register indices, one 32-bit word each; interrupt pair follows the lane word, 2C3 left free
   localparam logic [9:0]  AMLF_IDX_SUMMARY  = 10'h2C0;
   localparam logic [9:0]  AMLF_IDX_STATUS   = 10'h2C1;
   localparam logic [9:0]  AMLF_IDX_MASK     = 10'h2C2;
   localparam logic [9:0]  AMLF_IDX_LANE     = 10'h2C4;
   localparam logic [9:0]  AMLF_IDX_IRQ_ST   = 10'h2C5;
   localparam logic [9:0]  AMLF_IDX_IRQ_MSK  = 10'h2C6;
   // Register byte addresses, four times the index
   localparam logic [11:0] AMLF_ADDR_SUMMARY = {AMLF_IDX_SUMMARY, 2'h0};
   localparam logic [11:0] AMLF_ADDR_STATUS  = {AMLF_IDX_STATUS, 2'h0};
   localparam logic [11:0] AMLF_ADDR_MASK    = {AMLF_IDX_MASK, 2'h0};
   localparam logic [11:0] AMLF_ADDR_LANE    = {AMLF_IDX_LANE, 2'h0};
   localparam logic [11:0] AMLF_ADDR_IRQ_ST  = {AMLF_IDX_IRQ_ST, 2'h0};
   localparam logic [11:0] AMLF_ADDR_IRQ_MSK = {AMLF_IDX_IRQ_MSK, 2'h0};
   // Widths
   localparam int AMLF_ADDR_W = 12;
   localparam int AMLF_ALM_W  = 6;
   localparam int AMLF_LANES  = 16;
   localparam int AMLF_IRQ_W  = 2;
   // Alarm status and mask bit positions
   localparam int AMLF_BIT_DIV   = 0;
   localparam int AMLF_BIT_NCO   = 1;
   localparam int AMLF_BIT_REAL  = 2;
   localparam int AMLF_BIT_LINK  = 3;
   localparam int AMLF_BIT_LOCK  = 4;
   localparam int AMLF_BIT_FIFO  = 5;
   // Interrupt bit positions
   localparam int AMLF_IRQ_SUM   = 0;
   localparam int AMLF_IRQ_LANE  = 1;
   // Reset values
   localparam logic [5:0]  AMLF_RST_STATUS = 6'h3F;
   localparam logic [5:0]  AMLF_RST_MASK   = 6'h3F;
   localparam logic [15:0] AMLF_RST_LANE   = 16'hFFFF;
   localparam logic [1:0]  AMLF_RST_IRQ_ST = 2'h0;
   localparam logic [1:0]  AMLF_RST_IRQ_MK = 2'h0;
   // AXI responses
   localparam logic [1:0]  AMLF_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  AMLF_RESP_SLVERR = 2'h2;
endpackage : amlf_pkg

/* verification/tb_alarm_mask_and_lane_fifo_alarm.sv */
// Self-checking bench for the alarm mask, alarm status and lane fault flag block.
// Assumes amlf_pkg and amlf_top are compiled first; single 25 MHz clock domain.
`timescale 1ns/10ps
`default_nettype none
module tb_alarm_mask_and_lane_fifo_alarm;
   import amlf_pkg::*;
   // Design ports
   logic        clk_in, rst_n_in, lock_lost_in, link_fault_in, clock_realign_in;
   logic        divider_mismatch_in, summary_alarm_out, irq_out;
   logic [15:0] lane_fault_in;
   logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
   logic [3:0]  s_axi_wstrb_in;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
   logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
   logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
   logic        s_axi_rvalid_out, s_axi_rready_in;
   // Bench state
   int          err_count, cmp_count, cyc;
   logic [31:0] rd;
   logic [1:0]  rs;

   amlf_top dut_u (.clk_in, .rst_n_in, .lane_fault_in, .lock_lost_in, .link_fault_in,
      .clock_realign_in, .divider_mismatch_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
      .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
      .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
      .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
      .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .summary_alarm_out, .irq_out);

   // Clock
   always #20 clk_in = ~clk_in;

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("errors %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Write: address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_in);
      s_axi_awaddr_in  <= a;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wdata_in   <= d;
      s_axi_wvalid_in  <= 1'b1;
      s_axi_bready_in  <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
      end while (s_axi_bvalid_out !== 1'b1);
      r = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_in);
      s_axi_araddr_in  <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in  <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
      end while (s_axi_rvalid_out !== 1'b1);
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask : axi_rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      axi_wr(a, d, rs);
      chk(32'(rs), 32'(AMLF_RESP_OKAY));
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      axi_rd(a, rd, rs);
      chk(32'(rs), 32'(AMLF_RESP_OKAY));
      chk(rd, e);
   endtask : rd_chk

   // Drive one alarm source by status bit position
   task automatic src(input int b, input logic v);
      case (b)
         0: divider_mismatch_in <= v;
         2: clock_realign_in <= v;
         3: link_fault_in <= v;
         4: lock_lost_in <= v;
         default: lane_fault_in[0] <= v;
      endcase
   endtask : src

   task automatic pulse(input int b);
      @(posedge clk_in);
      src(b, 1'b1);
      @(posedge clk_in);
      src(b, 1'b0);
      repeat (3) @(posedge clk_in);
   endtask : pulse

   // One source, first unmasked then masked alone
   task automatic t_src(input int b);
      for (int m = 0; m < 2; m++) begin
         wr(AMLF_ADDR_MASK, m ? 32'h1 << b : 32'h0);
         pulse(b);
         chk(32'(summary_alarm_out), m ? 32'h0 : 32'h1);
         rd_chk(AMLF_ADDR_STATUS, 32'h1 << b);
         wr(AMLF_ADDR_STATUS, 32'h1 << b);
         repeat (2) @(posedge clk_in);
         chk(32'(summary_alarm_out), 32'h0);
      end
   endtask : t_src

   // Per-lane flags: set, single clear, persisting fault, bulk clear
   task automatic t_lane();
      @(posedge clk_in);
      lane_fault_in <= 16'h8008;
      @(posedge clk_in);
      lane_fault_in <= 16'h0000;
      rd_chk(AMLF_ADDR_LANE, 32'h8008);
      rd_chk(AMLF_ADDR_STATUS, 32'h20);
      wr(AMLF_ADDR_LANE, 32'h0008);
      rd_chk(AMLF_ADDR_LANE, 32'h8000);
      @(posedge clk_in);
      lane_fault_in <= 16'h0080;
      repeat (2) @(posedge clk_in);
      wr(AMLF_ADDR_LANE, 32'h0080);
      rd_chk(AMLF_ADDR_LANE, 32'h8080);
      @(posedge clk_in);
      lane_fault_in <= 16'h0000;
      wr(AMLF_ADDR_LANE, 32'h0080);
      rd_chk(AMLF_ADDR_LANE, 32'h8000);
      wr(AMLF_ADDR_STATUS, 32'h20);
      rd_chk(AMLF_ADDR_LANE, 32'h0);
      rd_chk(AMLF_ADDR_STATUS, 32'h0);
   endtask : t_lane

   // Interrupt raised, cleared by read, then masked
   task automatic t_irq();
      axi_rd(AMLF_ADDR_IRQ_ST, rd, rs);
      wr(AMLF_ADDR_IRQ_MSK, 32'h0);
      pulse(5);
      chk(32'(irq_out), 32'h1);
      rd_chk(AMLF_ADDR_IRQ_ST, 32'h2);
      @(posedge clk_in);
      chk(32'(irq_out), 32'h0);
      wr(AMLF_ADDR_IRQ_MSK, 32'h3);
      pulse(5);
      chk(32'(irq_out), 32'h0);
      rd_chk(AMLF_ADDR_IRQ_ST, 32'h2);
      rd_chk(AMLF_ADDR_IRQ_MSK, 32'h3);
   endtask : t_irq

   // Unmapped address on both channels, then a read of the summary word
   task automatic t_bus();
      axi_rd(12'h3FC, rd, rs);
      chk(32'(rs), 32'(AMLF_RESP_SLVERR));
      chk(rd, 32'h0);
      axi_wr(12'h3FC, 32'hFFFFFFFF, rs);
      chk(32'(rs), 32'(AMLF_RESP_SLVERR));
      rd_chk(AMLF_ADDR_SUMMARY, 32'h0);
   endtask : t_bus

   // Main sequence
   initial begin
      clk_in = 1'b0;
      rst_n_in = 1'b0;
      {lock_lost_in, link_fault_in, clock_realign_in, divider_mismatch_in} = 4'h0;
      lane_fault_in = 16'h0000;
      {s_axi_awaddr_in, s_axi_araddr_in} = 24'h0;
      s_axi_wdata_in = 32'h0;
      s_axi_wstrb_in = 4'hF;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
      {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
      err_count = 0;
      cmp_count = 0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd_chk(AMLF_ADDR_STATUS, 32'h3F);
      rd_chk(AMLF_ADDR_MASK, 32'h3F);
      rd_chk(AMLF_ADDR_LANE, 32'hFFFF);
      chk(32'(summary_alarm_out), 32'h0);
      wr(AMLF_ADDR_MASK, 32'h3D);
      repeat (3) @(posedge clk_in);
      chk(32'(summary_alarm_out), 32'h0);
      rd_chk(AMLF_ADDR_MASK, 32'h3D);
      // Leave only the unused status bit set, then unmask everything
      wr(AMLF_ADDR_STATUS, 32'h3D);
      wr(AMLF_ADDR_MASK, 32'h00);
      repeat (3) @(posedge clk_in);
      chk(32'(summary_alarm_out), 32'h0);
      rd_chk(AMLF_ADDR_STATUS, 32'h2);
      wr(AMLF_ADDR_STATUS, 32'h2);
      rd_chk(AMLF_ADDR_LANE, 32'h0);
      rd_chk(AMLF_ADDR_STATUS, 32'h0);
      for (int b = 0; b < 6; b++) begin
         if (b != 1) t_src(b);
      end
      t_lane();
      t_irq();
      t_bus();
      end_sim();
   end
endmodule : tb_alarm_mask_and_lane_fifo_alarm
`default_nettype wire
